/* src/spu_pkg.sv */
// Package: constants, enums and state struct of the serial port
package spu_pkg;
  // Operating modes
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_A8 = 2'h1;
  localparam logic [1:0] MODE_A9_FIXED = 2'h2;
  localparam logic [1:0] MODE_A9_TIMER = 2'h3;
  // Mode 0: twelve clocks per bit, shift clock low for the first six
  localparam logic [3:0] M0_DIV_LAST = 4'hb;
  localparam logic [3:0] M0_CLK_HIGH = 4'h6;
  localparam logic [3:0] M0_BITS = 4'h8;
  // Mode 2: sixteen ticks per bit, so a tick every 4 (/64) or 2 (/32) clocks
  localparam logic [1:0] M2_LAST_SLOW = 2'h3;
  localparam logic [1:0] M2_LAST_FAST = 2'h1;
  // Async oversampling
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] A8_BITS = 4'h8;
  localparam logic [3:0] A9_BITS = 4'h9;
  // Eight-bit baud timer rolls over from its top value
  localparam logic [7:0] T1_TOP = 8'hff;
  // Transmit buffer
  localparam logic [1:0] FIFO_FULL = 2'h2;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_STOP = 5'h08,
    TX_M0DONE = 5'h10
  } spu_tx_e;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } spu_rx_e;

  typedef struct packed {
    logic [2:0] sync;
    logic rx_lvl;
    logic rx_prev;
    logic [7:0] t1_cnt;
    logic t1_ovf;
    logic [1:0] m2_cnt;
    logic m2_tick;
    logic [1:0][7:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    spu_tx_e tx_st;
    logic tx_dir;
    logic [8:0] tx_sh;
    logic [3:0] tx_bit;
    logic [3:0] tx_ph;
    spu_rx_e rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_bit;
    logic [3:0] rx_ph;
    logic [7:0] hold;
    logic hold_full;
    logic ninth;
    logic tx_done;
    logic rx_done;
    logic ovr;
    logic irq;
    logic ready;
    logic ser_tx;
    logic ser_rx_o;
    logic ser_rx_oe;
  } spu_state_s;
endpackage

/* src/spu_serial_port.sv */
// Serial port: sync shift mode, 8/9-bit async modes, baud sources, buffers
// Notes on behaviour
// [R01] Mode 0 sync 8 bits, mode 1 async 8, modes 2/3 async 9 bits.
// [R02] Both done flags request interrupt if enabled; only software clears them.
// [R03] Received bytes go into a holding register; next reception may start.
// [R04] Overrun flags a byte latched while the held byte is still unread.
// [R05] One buffer: writes load the transmitter, reads return received data.
// [R06] Mode 0 half duplex: data on receive pin, shift clock on transmit pin.
// [R07] Mode 0 write sends eight bits LSB first; flag after eighth bit.
// [R08] Mode 0 receive starts with enable and clear flag; flag one cycle late.
// [R09] Mode 0 shift clock is system clock over 12; data pin open drain.
// [R10] Mode 1 frame: start, eight data bits LSB first, stop bit.
// [R11] Mode 1 write starts transmit; done flag at start of stop bit.
// [R12] Mode 1 receiver accepts frames only while receive enable is set.
// [R13] Load needs flag clear and, with check bit, stop bit high.
// [R14] Async baud logic gets one pulse per selected timer overflow.
// [R15] Transmit and receive baud sources selected by separate two-bit fields.
// [R16] With a wide timer, bit rate is overflow rate over sixteen.
// [R17] Eight-bit timer overflows at input rate over 256 minus reload.
// [R18] Mode 2 bit rate is system clock over 64, or 32 when doubled.
// [R19] Async receive oversamples 16x, finds falling start edge, samples mid-bit.
`timescale 1ns/100ps
module spu_serial_port (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic [1:0] MODE_I,
  input wire logic RX_ENABLE_I,
  input wire logic MULTIPROC_CHECK_I,
  input wire logic BAUD_DOUBLE_I,
  input wire logic INT_EN_I,
  input wire logic [1:0] TX_BAUD_SEL_I,
  input wire logic [1:0] RX_BAUD_SEL_I,
  input wire logic TIMER_ONE_CLK_I,
  input wire logic [7:0] TIMER_ONE_RELOAD_I,
  input wire logic [2:0] WIDE_TIMER_OVF_I,
  input wire logic BUF_WR_I,
  input wire logic [7:0] BUF_WDATA_I,
  input wire logic TX_NINTH_I,
  input wire logic BUF_RD_I,
  input wire logic TX_CLR_I,
  input wire logic RX_CLR_I,
  input wire logic OVR_CLR_I,
  input wire logic SER_RX_I,
  output logic BUF_WREADY_O,
  output logic [7:0] BUF_RDATA_O,
  output logic RX_NINTH_O,
  output logic TX_DONE_O,
  output logic RX_DONE_O,
  output logic RX_OVERRUN_O,
  output logic IRQ_O,
  output logic SER_TX_O,
  output logic SER_RX_O,
  output logic SER_RX_OE_O
);
  import spu_pkg::*;

  spu_state_s s;
  spu_state_s n;
  logic m0;
  logic fell;
  logic tx_tick;
  logic rx_tick;
  logic pop;
  logic push;
  logic load;
  logic [7:0] ld_data;
  logic ld_ninth;
  logic [3:0] nbits;
  logic [1:0] m2_last;

  // Baud tick source: fixed divider in mode 2, else the selected timer
  function automatic logic baud_tick(input logic [1:0] mode, input logic [1:0] sel,
                                     input logic t1, input logic [2:0] wide,
                                     input logic m2);
    logic t;
    t = t1;
    if (mode == MODE_A9_FIXED) begin
      t = m2;
    end else if (sel != 2'h0) begin
      t = wide[sel - 2'h1];
    end
    return t;
  endfunction

  // Whole next state in one pass
  always_comb begin
    n = s;
    pop = 1'b0;
    load = 1'b0;
    ld_data = 8'h00;
    ld_ninth = 1'b0;
    m0 = (MODE_I == MODE_SYNC); // [R01]
    nbits = MODE_I[1] ? A9_BITS : A8_BITS; // [R01]
    push = BUF_WR_I & s.ready;
    // Software clears come first so a same-cycle hardware set wins
    if (TX_CLR_I) n.tx_done = 1'b0; // [R02]
    if (RX_CLR_I) n.rx_done = 1'b0; // [R02]
    if (OVR_CLR_I) n.ovr = 1'b0;
    if (BUF_RD_I) n.hold_full = 1'b0;

    // Pin filter: level moves only when the last two stages agree
    n.sync = {s.sync[1:0], SER_RX_I};
    if (s.sync[2] == s.sync[1]) n.rx_lvl = s.sync[2];
    n.rx_prev = s.rx_lvl;
    fell = s.rx_prev & ~s.rx_lvl; // [R19]

    // Eight-bit auto-reload timer, one overflow pulse per rollover
    n.t1_ovf = 1'b0;
    if (TIMER_ONE_CLK_I) begin
      if (s.t1_cnt == T1_TOP) begin
        n.t1_cnt = TIMER_ONE_RELOAD_I; // [R17]
        n.t1_ovf = 1'b1;
      end else begin
        n.t1_cnt = s.t1_cnt + 8'h01;
      end
    end

    // Fixed mode 2 tick, sixteen per bit
    n.m2_tick = 1'b0;
    m2_last = BAUD_DOUBLE_I ? M2_LAST_FAST : M2_LAST_SLOW; // [R18]
    if (s.m2_cnt >= m2_last) begin
      n.m2_cnt = 2'h0;
      n.m2_tick = 1'b1;
    end else begin
      n.m2_cnt = s.m2_cnt + 2'h1;
    end

    // Independent sources; a wide timer gives 16 ticks per bit
    tx_tick = baud_tick(MODE_I, TX_BAUD_SEL_I, s.t1_ovf, WIDE_TIMER_OVF_I,
                        s.m2_tick); // [R14] [R15] [R16]
    rx_tick = baud_tick(MODE_I, RX_BAUD_SEL_I, s.t1_ovf, WIDE_TIMER_OVF_I,
                        s.m2_tick); // [R14] [R15] [R16]

    // Transmitter, which also runs both directions of mode 0
    unique case (s.tx_st)
      TX_IDLE: begin
        n.ser_tx = 1'b1;
        n.ser_rx_oe = 1'b0;
        n.tx_bit = 4'h0;
        n.tx_ph = 4'h0;
        if (s.cnt != 2'h0) begin
          pop = 1'b1; // [R05] [R11]
          n.tx_sh = {TX_NINTH_I, s.fifo[s.rp]};
          n.tx_dir = 1'b0;
          n.tx_st = m0 ? TX_DATA : TX_START; // [R07]
        end else if (m0 && RX_ENABLE_I && !s.rx_done) begin
          n.tx_dir = 1'b1; // [R08]
          n.tx_st = TX_DATA;
        end
      end
      TX_START: begin
        n.ser_tx = 1'b0; // [R10]
        if (tx_tick) begin
          n.tx_ph = s.tx_ph + 4'h1;
          if (s.tx_ph == OVS_LAST) n.tx_st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (m0) begin
          // Device is always master of the shift clock
          n.ser_tx = (s.tx_ph >= M0_CLK_HIGH); // [R06] [R09]
          n.ser_rx_oe = ~s.tx_dir & ~s.tx_sh[0]; // [R09]
          n.tx_ph = s.tx_ph + 4'h1;
          if (s.tx_ph == M0_DIV_LAST) begin
            n.tx_ph = 4'h0;
            n.tx_bit = s.tx_bit + 4'h1;
            if (s.tx_dir) n.tx_sh = {1'b0, s.rx_lvl, s.tx_sh[7:1]}; // [R06]
            else n.tx_sh = {1'b0, s.tx_sh[8:1]}; // [R07]
            if (s.tx_bit == M0_BITS - 4'h1) begin
              n.tx_st = s.tx_dir ? TX_M0DONE : TX_IDLE;
              if (!s.tx_dir) n.tx_done = 1'b1; // [R07]
            end
          end
        end else begin
          n.ser_tx = s.tx_sh[0]; // [R10]
          if (tx_tick) begin
            n.tx_ph = s.tx_ph + 4'h1;
            if (s.tx_ph == OVS_LAST) begin
              n.tx_sh = {1'b1, s.tx_sh[8:1]};
              n.tx_bit = s.tx_bit + 4'h1;
              if (s.tx_bit == nbits - 4'h1) begin
                n.tx_st = TX_STOP;
                n.tx_done = 1'b1; // [R11]
              end
            end
          end
        end
      end
      TX_STOP: begin
        n.ser_tx = 1'b1; // [R10]
        if (tx_tick) begin
          n.tx_ph = s.tx_ph + 4'h1;
          if (s.tx_ph == OVS_LAST) n.tx_st = TX_IDLE;
        end
      end
      TX_M0DONE: begin
        // Flag and data land one cycle after the eighth bit
        load = 1'b1; // [R08]
        ld_data = s.tx_sh[7:0];
        ld_ninth = s.ninth;
        n.tx_st = TX_IDLE;
      end
    endcase

    // Async receiver, parked in mode 0 where the pin is shared
    unique case (s.rx_st)
      RX_IDLE: begin
        n.rx_ph = 4'h0;
        n.rx_bit = 4'h0;
        if (!m0 && RX_ENABLE_I && fell) n.rx_st = RX_START; // [R12] [R19]
      end
      RX_START: begin
        if (rx_tick) begin
          n.rx_ph = s.rx_ph + 4'h1;
          // A start bit that is gone by mid-bit was a glitch
          if (s.rx_ph == OVS_MID) begin
            n.rx_ph = 4'h0;
            n.rx_st = s.rx_lvl ? RX_IDLE : RX_DATA; // [R19]
          end
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          n.rx_ph = s.rx_ph + 4'h1;
          if (s.rx_ph == OVS_LAST) begin
            n.rx_sh = {s.rx_lvl, s.rx_sh[8:1]}; // [R19]
            n.rx_bit = s.rx_bit + 4'h1;
            if (s.rx_bit == nbits - 4'h1) n.rx_st = RX_STOP; // [R10]
          end
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          n.rx_ph = s.rx_ph + 4'h1;
          if (s.rx_ph == OVS_LAST) begin
            n.rx_st = RX_IDLE;
            ld_data = MODE_I[1] ? s.rx_sh[7:0] : s.rx_sh[8:1];
            ld_ninth = MODE_I[1] ? s.rx_sh[8] : s.rx_lvl; // [R13]
            load = !s.rx_done && (!MULTIPROC_CHECK_I || ld_ninth); // [R13]
          end
        end
      end
    endcase

    // Holding register, so the shifter is free for the next byte
    if (load) begin
      if (s.hold_full) n.ovr = 1'b1; // [R04]
      n.hold = ld_data; // [R03] [R05]
      n.ninth = ld_ninth; // [R13]
      n.rx_done = 1'b1; // [R13]
      n.hold_full = 1'b1;
    end

    // Two-entry transmit buffer; a busy shifter backs up into it
    if (push) begin
      n.fifo[s.wp] = BUF_WDATA_I; // [R05]
      n.wp = ~s.wp;
    end
    if (pop) n.rp = ~s.rp;
    n.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
    n.ready = (n.cnt != FIFO_FULL);
    n.irq = INT_EN_I & (n.tx_done | n.rx_done); // [R02]

    if (SRST_I) begin
      n = '0;
      n.sync = 3'h7;
      n.rx_lvl = 1'b1;
      n.rx_prev = 1'b1;
      n.tx_st = TX_IDLE;
      n.rx_st = RX_IDLE;
      n.ser_tx = 1'b1;
      n.ready = 1'b1;
    end
  end

  // State register
  always_ff @(posedge CLOCK_I) begin
    s <= n;
  end

  // All outputs come straight from state flops
  assign BUF_WREADY_O = s.ready;
  assign BUF_RDATA_O = s.hold;
  assign RX_NINTH_O = s.ninth;
  assign TX_DONE_O = s.tx_done;
  assign RX_DONE_O = s.rx_done;
  assign RX_OVERRUN_O = s.ovr;
  assign IRQ_O = s.irq;
  assign SER_TX_O = s.ser_tx;
  assign SER_RX_O = s.ser_rx_o;
  assign SER_RX_OE_O = s.ser_rx_oe;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SRST_I);

  // Checks on flags, framing and rates
  tx_flag_hold_a: assert property (s.tx_done && !TX_CLR_I |=> s.tx_done) // [R02]
    else $error("tx done flag dropped without clear");
  irq_gate_a: assert property ($rose(s.rx_done) && $past(INT_EN_I) |-> IRQ_O) // [R02]
    else $error("interrupt missing on receive done");
  rx_hold_data_a: assert property (load |=> BUF_RDATA_O == $past(ld_data)) // [R03]
    else $error("holding register did not take received byte");
  overrun_set_a: assert property (load && s.hold_full |=> RX_OVERRUN_O) // [R04]
    else $error("overrun not flagged");
  m0_clk_low_a: assert property (m0 && s.tx_st == TX_DATA && s.tx_ph == 4'h0 |=> // [R09]
    !SER_TX_O [*6])
    else $error("shift clock low phase not six clocks");
  m0_rx_flag_a: assert property (s.tx_st == TX_M0DONE |=> s.rx_done && s.tx_st == TX_IDLE) // [R08]
    else $error("mode 0 receive flag late");
  start_low_a: assert property (s.tx_st == TX_START |=> !SER_TX_O) // [R10]
    else $error("start bit not low");
  stop_flag_a: assert property ($rose(s.tx_st == TX_STOP) |-> s.tx_done) // [R11]
    else $error("tx flag not set at stop bit start");
  rx_off_a: assert property (s.rx_st == RX_IDLE && !RX_ENABLE_I |=> s.rx_st == RX_IDLE) // [R12]
    else $error("receiver left idle while disabled");
  load_block_a: assert property (s.rx_st == RX_STOP && s.rx_done |=> $stable(s.hold)) // [R13]
    else $error("byte loaded over pending flag");
  t1_reload_a: assert property (TIMER_ONE_CLK_I && s.t1_cnt == T1_TOP |=> // [R17]
    s.t1_ovf && s.t1_cnt == $past(TIMER_ONE_RELOAD_I))
    else $error("timer reload or overflow wrong");
  // Rate must stay slow for the whole window, a switch to doubled may tick early
  m2_rate_a: assert property (s.m2_tick && !BAUD_DOUBLE_I ##1 !BAUD_DOUBLE_I |-> // [R18]
    !s.m2_tick ##1 !s.m2_tick)
    else $error("mode 2 tick too fast");

  // Main scenarios
  rx_frame_c: cover property (load && MODE_I == MODE_A8);
  m0_tx_c: cover property (m0 && $rose(s.tx_done));
  overrun_c: cover property ($rose(s.ovr));
  fifo_full_c: cover property (!s.ready);
endmodule

/* bench/spu_remote.sv */
// Remote peer: async serial end and mode 0 shift register
`timescale 1ns/100ps
module spu_remote (
  input wire logic clk_i,
  input wire logic shift_i,
  input wire logic [7:0] bclk_i,
  input wire logic [3:0] nb_i,
  input wire logic tx_i,
  input wire logic pin_i,
  output logic line_o,
  output logic [8:0] got_o
);
  logic [7:0] sh;
  int nleft = 0;
  initial line_o = 1'b1;
  // Frame capture from start edge, mid-bit, LSB first
  always begin
    @(negedge tx_i);
    if (!shift_i) begin
      repeat (bclk_i / 2) @(posedge clk_i);
      repeat (nb_i) begin
        repeat (bclk_i) @(posedge clk_i);
        got_o = {tx_i, got_o[8:1]};
      end
    end
  end
  // Shift slave: next bit after falling clock, idle high once empty
  always @(negedge tx_i) begin
    if (shift_i) begin
      line_o <= (nleft > 0) ? sh[0] : 1'b1;
      sh <= sh >> 1;
      nleft <= (nleft > 0) ? nleft - 1 : 0;
    end
  end
  always @(posedge tx_i) if (shift_i) got_o <= {pin_i, got_o[8:1]};
  // Start, data LSB first, chosen stop level
  task automatic send(input logic [8:0] d, input logic stop);
    @(negedge clk_i) line_o = 1'b0;
    for (int i = 0; i <= nb_i; i++) begin
      repeat (bclk_i) @(negedge clk_i);
      line_o = (i == nb_i) ? stop : d[i];
    end
    repeat (bclk_i) @(negedge clk_i);
    line_o = 1'b1;
  endtask
  task automatic load(input logic [7:0] d);
    sh = d;
    nleft = 8;
  endtask
endmodule

/* bench/test_spu_serial_port.sv */
// Self-checking bench for the serial port
`timescale 1ns/100ps
module test_spu_serial_port;
  import spu_pkg::*;
  logic clk, srst, rx_en, mp, dbl, int_en, wr, ninth, rd, txc, rxc, ovc;
  logic [1:0] mode, tsel, rsel;
  logic [7:0] reload, wdata, rdata, bclk, exp_d;
  logic [2:0] wide = 3'h0;
  logic t1slow = 1'b0;
  logic timer_one_input_clock = 1'b1;
  logic [3:0] nb;
  logic [8:0] got;
  logic wready, rx9, txd, rxd, ovr, irq, stx, srx, oe, line;
  logic [31:0] seed = 32'hdc0d;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  wire pin = oe ? srx : line;
  spu_serial_port DUT (.CLOCK_I(clk), .SRST_I(srst), .MODE_I(mode), .RX_ENABLE_I(rx_en),
    .MULTIPROC_CHECK_I(mp), .BAUD_DOUBLE_I(dbl), .INT_EN_I(int_en), .TX_BAUD_SEL_I(tsel),
    .RX_BAUD_SEL_I(rsel), .TIMER_ONE_CLK_I(timer_one_input_clock), .TIMER_ONE_RELOAD_I(reload),
    .WIDE_TIMER_OVF_I(wide), .BUF_WR_I(wr), .BUF_WDATA_I(wdata), .TX_NINTH_I(ninth),
    .BUF_RD_I(rd), .TX_CLR_I(txc), .RX_CLR_I(rxc), .OVR_CLR_I(ovc), .SER_RX_I(pin),
    .BUF_WREADY_O(wready), .BUF_RDATA_O(rdata), .RX_NINTH_O(rx9), .TX_DONE_O(txd),
    .RX_DONE_O(rxd), .RX_OVERRUN_O(ovr), .IRQ_O(irq), .SER_TX_O(stx), .SER_RX_O(srx),
    .SER_RX_OE_O(oe));
  spu_remote peer (.clk_i(clk), .shift_i(mode == MODE_SYNC), .bclk_i(bclk), .nb_i(nb),
    .tx_i(stx), .pin_i(pin), .line_o(line), .got_o(got));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Wide timers overflow every 2, 4 and 8 clocks, so a wrong select shows
  // Eight-bit timer counts every clock, or every other one when slowed
  always @(negedge clk) begin
    cyc <= cyc + 1;
    wide <= {cyc[2:0] == 3'h0, cyc[1:0] == 2'h0, cyc[0]};
    timer_one_input_clock <= !t1slow || cyc[0];
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Clocks per bit: sixteen ticks of the chosen source
  function automatic int bit_clks(input logic [1:0] m, s, input logic [7:0] r, input logic d, h);
    if (m == MODE_A9_FIXED) return d ? 32 : 64;
    return (s == 2'h0) ? (16 * (256 - r)) << h : 16 << s;
  endfunction
  task automatic chk(input logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Cycle counts allow for tick phase and pipeline lag
  task automatic near(input int g, e);
    chk(16'((g >= e - 4 && g <= e + 12) ? e : g), 16'(e));
  endtask
  task automatic put(input logic [7:0] d);
    @(negedge clk) wr = 1'b1;
    wdata = d;
    @(negedge clk) wr = 1'b0;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(negedge clk) {rd, ovc, rxc, txc} = m;
    @(negedge clk) {rd, ovc, rxc, txc} = 4'h0;
  endtask
  task automatic wait_flag(input logic rx);
    n = 0;
    while ((rx ? rxd : txd) !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 8000) chk(16'h0, 16'h1);
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    {srst, rx_en, mp, dbl, int_en, wr, ninth, rd, txc, rxc, ovc} = 11'h440;
    {mode, tsel, rsel, nb} = {MODE_A8, 4'h0, 4'h8};
    {reload, wdata, bclk} = {8'hfc, 8'h00, 8'h40};
    repeat (8) @(negedge clk);
    srst = 1'b0;
    chk({wready, txd, rxd, ovr, irq, stx, oe, rdata}, {7'h42, 8'h00});
    // Timer starts from zero, so its first rollover is a long way off
    repeat (300) @(negedge clk);
    // Every baud source and async mode, random data and ninth bit
    for (int k = 0; k < 8; k++) begin
      mode = k < 5 ? MODE_A8 : (k < 7 ? MODE_A9_FIXED : MODE_A9_TIMER);
      tsel = k < 2 ? 2'h0 : (k < 5 ? 2'(k - 1) : 2'h2);
      rsel = ~tsel;
      reload = k == 1 ? 8'hfe : 8'hfc;
      dbl = k == 6;
      t1slow = k == 1;
      nb = mode == MODE_A8 ? 4'h8 : 4'h9;
      bclk = 8'(bit_clks(mode, tsel, reload, dbl, t1slow));
      seed = lfsr(seed);
      ninth = seed[8];
      put(seed[7:0]);
      wait_flag(1'b0);
      near(n, (1 + nb) * bclk);
      chk(got >> (9 - nb), {nb == 9 && seed[8], seed[7:0]});
      // Pin follows the state a cycle late, so the stop level shows after the flag
      repeat (2) @(negedge clk);
      chk({stx, irq, txd}, 3'h7);
      pulse(4'h1);
      @(negedge clk);
      chk({irq, txd}, 2'h0);
      repeat (bclk) @(negedge clk);
    end
    // Fill the two-entry buffer behind a busy sender; a fourth write drops
    ninth = 1'b1;
    for (int k = 0; k < 3; k++) put(8'(8'h5a + k));
    repeat (2) @(negedge clk);
    chk(wready, 1'b0);
    put(8'ha5);
    for (int k = 0; k < 3; k++) begin
      wait_flag(1'b0);
      chk(got, {1'b1, 8'(8'h5a + k)});
      pulse(4'h1);
      repeat (bclk) @(negedge clk);
    end
    repeat (800) @(negedge clk);
    chk(txd, 1'b0);
    // Receive cases: held flag, overrun, check bit, stop level, disable
    {mode, nb, rsel, tsel, bclk, exp_d} = {MODE_A8, 4'h8, 4'h8, 8'h40, 8'h00};
    for (int k = 0; k < 6; k++) begin
      rx_en = k != 4;
      mp = k == 3 || k == 5;
      pulse(k == 2 ? 4'h2 : (k == 3 ? 4'he : 4'h0));
      seed = lfsr(seed);
      peer.send({1'b0, seed[7:0]}, k != 3);
      repeat (8) @(negedge clk);
      if (k != 1 && k != 3 && k != 4) exp_d = seed[7:0];
      chk({rdata, rx9, rxd, ovr}, {exp_d, 1'b1, k != 3 && k != 4, k == 2});
    end
    // Shift mode: clock a byte out, then one in, then hold
    rx_en = 1'b0;
    pulse(4'hf);
    mode = MODE_SYNC;
    seed = lfsr(seed);
    put(seed[7:0]);
    wait_flag(1'b0);
    near(n, 96);
    chk(got[8:1], seed[7:0]);
    seed = lfsr(seed);
    peer.load(seed[7:0]);
    pulse(4'h1);
    rx_en = 1'b1;
    wait_flag(1'b1);
    repeat (48) @(negedge clk);
    chk({stx, oe, rdata}, {2'b10, seed[7:0]});
    stop_test();
  end
endmodule
